// ### pmc_pkg.sv
/*
 * constants and carrier types for the pdm microphone capture block.
 * assumes a 100 MHz system clock and a separate fast link clock.
 */
`default_nettype none

package pmc_pkg;
	// clock plan
	localparam int MIC_CLK_KHZ  = 2400;
	localparam int LINK_CLK_KHZ = 166_667;
	localparam int MIC_HALF_DIV = LINK_CLK_KHZ / (2 * MIC_CLK_KHZ);
	localparam int DIV_W        = 8;

	// output sample rates and decimation ratios
	localparam int RATE_LO_KHZ = 8;
	localparam int RATE_HI_KHZ = 16;
	localparam int DECIM_LO    = MIC_CLK_KHZ / RATE_LO_KHZ;
	localparam int DECIM_HI    = MIC_CLK_KHZ / RATE_HI_KHZ;
	localparam int DEC_W       = 9;

	// filter widths and output field positions
	localparam int CIC_W     = 26;
	localparam int SAMPLE_W  = 16;
	localparam int LO_MSB    = 25;
	localparam int HI_MSB    = 22;
	localparam int FIFO_DEPTH = 4;

	typedef enum logic {
		PMC_RATE_8K  = 1'b0,
		PMC_RATE_16K = 1'b1
	} pmc_rate_e;

	typedef struct packed {
		logic [SAMPLE_W-1:0] ch1;
		logic [SAMPLE_W-1:0] ch0;
	} pmc_pair_s;

	typedef struct packed {
		logic      src_aux;
		pmc_rate_e rate;
		logic      edge_sel;
	} pmc_cfg_s;
endpackage

`default_nettype wire

// ### pmc_fifo.sv
/*
 * small synchronous fifo, width and depth as parameters.
 * assumes one clock; depth is a power of two.
 */
`default_nettype none

module pmc_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	logic         push;
	logic         pop;

	// full when pointers differ only in the wrap bit
	assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
	assign out_valid = (wr_q != rd_q);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q[AW-1:0]];

	// storage has no reset; empty pointers mask stale words
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// ### pmc_capture.sv
/*
 * pdm microphone capture: mic clock generation, edge sampling, stereo
 * cic decimation and hand-over of sample pairs to the system clock.
 * assumes link_clk near 166 MHz and mics that share one data line.
 */
// Operation
// - the block divides its link clock down to a 2.4 MHz clock and drives it to the mics.
// - a control bit chooses whether the data line is taken on the rising or falling mic clock edge.
// - each channel takes exactly one bit of its pulse-density stream per mic clock period, ch0 on the chosen edge and ch1 on the other.
// - the bit streams are decimated and filtered down to 8 kHz or 16 kHz samples.
// - two channels are captured at once so a stereo pair comes out together.
// - the ch0 filter path is shared with the auxiliary converter stream, chosen by a source bit.
`default_nettype none

module pmc_capture (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              link_clk,
	input  wire pmc_pkg::pmc_cfg_s cfg,
	output logic                   mic_clk,
	input  wire logic              mic_data,
	input  wire logic              aux_conv_bit,
	output pmc_pkg::pmc_pair_s     sample_out,
	output logic                   sample_valid,
	input  wire logic              sample_ready,
	output logic [1:0]             sample_strobe,
	output logic                   overrun,
	input  wire logic              overrun_clr
);
	localparam int DL = pmc_pkg::DECIM_LO - 1;
	localparam int DH = pmc_pkg::DECIM_HI - 1;
	localparam int HD = pmc_pkg::MIC_HALF_DIV - 1;
	localparam int CW = pmc_pkg::CIC_W;

	////////////////////////////////////////////////////////////////////////
	// link domain reset and input synchronisers

	logic [1:0]              lrst_q;
	logic                    link_rst;
	pmc_pkg::pmc_cfg_s       cfg_m_q;
	pmc_pkg::pmc_cfg_s       cfg_s_q;
	logic [1:0]              pin_m_q;
	logic [1:0]              pin_s_q;

	// async assert, sync release
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lrst_q <= 2'b11;
		end else begin
			lrst_q <= {lrst_q[0], 1'b0};
		end
	end
	assign link_rst = lrst_q[1];

	// config levels and both pins through two flops each
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			cfg_m_q <= '0;
			cfg_s_q <= '0;
			pin_m_q <= 2'b00;
			pin_s_q <= 2'b00;
		end else begin
			cfg_m_q <= cfg;
			cfg_s_q <= cfg_m_q;
			pin_m_q <= {aux_conv_bit, mic_data};
			pin_s_q <= pin_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mic clock divider

	logic [pmc_pkg::DIV_W-1:0] div_q;
	logic                      mclk_q;
	logic                      term;
	logic                      rise_tick;
	logic                      fall_tick;

	assign term      = (div_q == HD[pmc_pkg::DIV_W-1:0]);
	assign rise_tick = term && !mclk_q;
	assign fall_tick = term && mclk_q;
	assign mic_clk   = mclk_q;

	// free-running divide, half period of MIC_HALF_DIV link cycles
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			div_q  <= '0;
			mclk_q <= 1'b0;
		end else begin
			div_q <= term ? '0 : div_q + 1'b1;
			if (term) begin
				mclk_q <= !mclk_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge pick and source select

	logic [1:0] tick;
	logic [1:0] bit_in;

	// mic data settles well before our edge, so the synced value is the edge value
	assign tick[0]   = cfg_s_q.edge_sel ? fall_tick : rise_tick;
	assign tick[1]   = cfg_s_q.edge_sel ? rise_tick : fall_tick;
	assign bit_in[0] = cfg_s_q.src_aux ? pin_s_q[1] : pin_s_q[0];
	assign bit_in[1] = pin_s_q[0];

	////////////////////////////////////////////////////////////////////////
	// decimation counter, one count per mic clock period

	logic [pmc_pkg::DEC_W-1:0] dec_q;
	logic [pmc_pkg::DEC_W-1:0] dec_last;
	logic                      dec;

	assign dec_last = (cfg_s_q.rate == pmc_pkg::PMC_RATE_16K) ?
		DH[pmc_pkg::DEC_W-1:0] : DL[pmc_pkg::DEC_W-1:0];
	assign dec = rise_tick && (dec_q >= dec_last);

	// a rate change lands at the next wrap at the latest
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			dec_q <= '0;
		end else if (rise_tick) begin
			dec_q <= dec ? '0 : dec_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// third order cic per channel

	pmc_pkg::pmc_pair_s hold_q;
	logic               req_q;
	logic [CW-1:0]      i1_q [2];
	logic [CW-1:0]      i2_q [2];
	logic [CW-1:0]      i3_q [2];
	logic [CW-1:0]      d1_q [2];
	logic [CW-1:0]      d2_q [2];
	logic [CW-1:0]      d3_q [2];
	logic [CW-1:0]      c1   [2];
	logic [CW-1:0]      c2   [2];
	logic [CW-1:0]      c3   [2];
	logic [pmc_pkg::SAMPLE_W-1:0] scaled [2];

	for (genvar ch = 0; ch < 2; ch++) begin : g_cic
		// one bit maps to plus or minus one
		always_ff @(posedge link_clk or posedge link_rst) begin
			if (link_rst) begin
				i1_q[ch] <= '0;
				i2_q[ch] <= '0;
				i3_q[ch] <= '0;
			end else if (tick[ch]) begin
				i1_q[ch] <= bit_in[ch] ? i1_q[ch] + 1'b1 : i1_q[ch] - 1'b1;
				i2_q[ch] <= i2_q[ch] + i1_q[ch];
				i3_q[ch] <= i3_q[ch] + i2_q[ch];
			end
		end

		// combs at the output rate; wrap arithmetic cancels
		always_comb begin
			c1[ch] = i3_q[ch] - d1_q[ch];
			c2[ch] = c1[ch] - d2_q[ch];
			c3[ch] = c2[ch] - d3_q[ch];
			scaled[ch] = (cfg_s_q.rate == pmc_pkg::PMC_RATE_16K) ?
				c3[ch][pmc_pkg::HI_MSB -: pmc_pkg::SAMPLE_W] :
				c3[ch][pmc_pkg::LO_MSB -: pmc_pkg::SAMPLE_W];
		end

		always_ff @(posedge link_clk or posedge link_rst) begin
			if (link_rst) begin
				d1_q[ch] <= '0;
				d2_q[ch] <= '0;
				d3_q[ch] <= '0;
			end else if (dec) begin
				d1_q[ch] <= i3_q[ch];
				d2_q[ch] <= c1[ch];
				d3_q[ch] <= c2[ch];
			end
		end

		one_bit_a: assert property (@(posedge link_clk) disable iff (link_rst)
			tick[ch] |=> i1_q[ch] == $past(i1_q[ch]) + ($past(bit_in[ch]) ? CW'(1) : CW'(-1)))
			else $error("integrator did not step by one bit");
	end

	// both channels latched together, then one toggle per pair
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			hold_q <= '0;
			req_q  <= 1'b0;
		end else if (dec) begin
			hold_q.ch0 <= scaled[0];
			hold_q.ch1 <= scaled[1];
			req_q      <= !req_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crossing into ref_clk and output fifo

	logic [2:0] ack_q;
	logic       arrive;
	logic       in_ready;
	logic       ovr_q;

	// hold_q stands for a whole output period, far longer than the sync delay
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 3'b000;
		end else begin
			ack_q <= {ack_q[1:0], req_q};
		end
	end
	assign arrive = ack_q[1] ^ ack_q[2];

	// live stream cannot stall; a full fifo drops the pair and flags it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ovr_q <= 1'b0;
		end else if (arrive && !in_ready) begin
			ovr_q <= 1'b1;
		end else if (overrun_clr) begin
			ovr_q <= 1'b0;
		end
	end
	assign overrun = ovr_q;

	pmc_fifo #(
		.W     ($bits(pmc_pkg::pmc_pair_s)),
		.DEPTH (pmc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (ref_clk),
		.rst       (rst),
		.in_valid  (arrive),
		.in_ready  (in_ready),
		.in_data   (hold_q),
		.out_valid (sample_valid),
		.out_ready (sample_ready),
		.out_data  (sample_out)
	);

	// strobe marks the cycle a pair is taken
	assign sample_strobe = {2{sample_valid && sample_ready}};

	////////////////////////////////////////////////////////////////////////
	// checks

	mic_clk_div_a: assert property (@(posedge link_clk) disable iff (link_rst)
		$changed(mclk_q) |-> $past(div_q) == HD[pmc_pkg::DIV_W-1:0])
		else $error("mic clock toggled off the divider terminal");
	edge_pick_a: assert property (@(posedge link_clk) disable iff (link_rst)
		tick[0] |=> mclk_q == !$past(cfg_s_q.edge_sel))
		else $error("channel 0 took its bit on the wrong edge");
	decim_ratio_a: assert property (@(posedge link_clk) disable iff (link_rst)
		dec |-> rise_tick && dec_q == dec_last)
		else $error("decimation fired at the wrong count");
	stereo_pair_a: assert property (@(posedge link_clk) disable iff (link_rst)
		$changed(req_q) |-> $past(dec))
		else $error("pair toggle without decimation");
	shared_path_a: assert property (@(posedge link_clk) disable iff (link_rst)
		cfg_s_q.src_aux |-> bit_in[0] == pin_s_q[1])
		else $error("auxiliary stream not routed into filter");
	strobe_take_a: assert property (@(posedge ref_clk) disable iff (rst)
		sample_strobe[0] |-> sample_valid && sample_ready && sample_strobe[1])
		else $error("sample strobe without a taken pair");
	hold_until_take_a: assert property (@(posedge ref_clk) disable iff (rst)
		sample_valid && !sample_ready |=> sample_valid && $stable(sample_out))
		else $error("offered pair changed before it was taken");
	overrun_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		arrive && !in_ready |=> overrun)
		else $error("dropped pair not flagged");
	arrive_push_a: assert property (@(posedge ref_clk) disable iff (rst)
		arrive && in_ready |=> sample_valid)
		else $error("arriving pair not offered");

	cover_16k_c: cover property (@(posedge link_clk) disable iff (link_rst)
		dec && cfg_s_q.rate == pmc_pkg::PMC_RATE_16K);
	cover_fall_c: cover property (@(posedge link_clk) disable iff (link_rst)
		tick[0] && cfg_s_q.edge_sel);
	cover_take_c: cover property (@(posedge ref_clk) disable iff (rst) sample_strobe[0]);
	cover_ovr_c: cover property (@(posedge ref_clk) disable iff (rst) arrive && !in_ready);
endmodule

`default_nettype wire

// ### pmc_mic_pair.sv
/*
 * model of two pdm microphones sharing one data line.
 * assumes the device holds its mic clock low while in reset.
 */
`default_nettype none

module pmc_mic_pair (
	input  wire logic mic_clk,
	input  wire logic sel,
	input  wire logic ch0_bit,
	input  wire logic ch1_bit,
	output logic      mic_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// each mic owns one clock half; the line changes shortly after the edge
	always @(mic_clk or sel) begin
		mic_data <= #3 (mic_clk ^ sel) ? ch1_bit : ch0_bit;
	end
endmodule

`default_nettype wire

// ### tb.sv
/*
 * self-checking bench for the pdm capture block.
 * assumes the mic pair model and the design files are compiled first.
 */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic               ref_clk, link_clk, rst, mic_clk, mic_data, aux_bit;
	logic               valid, ready, ovr, ovr_clr;
	logic [1:0]         strobe;
	pmc_pkg::pmc_cfg_s  cfg;
	pmc_pkg::pmc_pair_s pair;
	int                 num_errors, checks_done;
	realtime            t_last, t_gap;

	////////////////////////////////////////////////////////////////////////
	// clocks: link clock phase offset so the domains never line up
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		#1.3;
		forever #3 link_clk = ~link_clk;
	end

	pmc_capture dut_u (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .cfg(cfg),
		.mic_clk(mic_clk), .mic_data(mic_data), .aux_conv_bit(aux_bit),
		.sample_out(pair), .sample_valid(valid), .sample_ready(ready),
		.sample_strobe(strobe), .overrun(ovr), .overrun_clr(ovr_clr));

	// ch0 mic is all ones, ch1 mic all zeros, so signs show routing;
	// the mics keep their clock halves whatever edge the device picks
	pmc_mic_pair mic_u (.mic_clk(mic_clk), .sel(1'b0), .ch0_bit(1'b1),
		.ch1_bit(1'b0), .mic_data(mic_data));

	////////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic stop_test();
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// take one pair; ready only for one edge so nothing is popped unseen
	task automatic pop(output pmc_pkg::pmc_pair_s p);
		int n;
		// a full low cycle of ready before each new take
		for (n = 0; n < 20000; n++) begin
			@(negedge ref_clk);
			if (valid === 1'b1) break;
		end
		if (valid !== 1'b1) begin
			num_errors++;
			stop_test();
		end
		ready = 1'b1;
		#1;
		check(32'(strobe), 32'h0000_0003);
		p = pair;
		t_gap = $realtime - t_last;
		t_last = $realtime;
		@(negedge ref_clk);
		ready = 1'b0;
	endtask

	// pop cnt pairs, judge signs of the last and, if decim given, its spacing
	task automatic drain(input int cnt, input int decim, input logic [1:0] sign);
		pmc_pkg::pmc_pair_s p;
		real                want;
		want = real'(decim * 2 * pmc_pkg::MIC_HALF_DIV) * 6.0;
		for (int i = 0; i < cnt; i++) pop(p);
		check(32'({p.ch1[15], p.ch0[15]}), 32'(sign));
		if (decim != 0) begin
			check(32'(t_gap > want - 30.0 && t_gap < want + 30.0), 32'h0000_0001);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic s_clock();
		int   n;
		logic prev;
		n = 0;
		for (int k = 0; k < 2; k++) begin
			prev = mic_clk;
			for (n = 0; n < 200 && mic_clk === prev; n++) @(negedge link_clk);
		end
		check(32'(n), 32'(pmc_pkg::MIC_HALF_DIV));
		@(negedge ref_clk);
	endtask

	task automatic s_stereo();
		drain(3, pmc_pkg::DECIM_HI, 2'b10);
	endtask

	// swapped edge with the consumer stalled until the buffer refuses
	task automatic s_fill();
		int n;
		cfg.edge_sel = 1'b1;
		for (n = 0; n < 40000 && ovr !== 1'b1; n++) @(negedge ref_clk);
		check(32'(ovr), 32'h0000_0001);
		drain(4, 0, 2'b01);
		check(32'(valid), 32'h0000_0000);
		ovr_clr = 1'b1;
		@(negedge ref_clk);
		ovr_clr = 1'b0;
		check(32'(ovr), 32'h0000_0000);
	endtask

	// auxiliary stream on ch0 at the low rate
	task automatic s_aux();
		cfg.edge_sel = 1'b0;
		cfg.src_aux = 1'b1;
		cfg.rate = pmc_pkg::PMC_RATE_8K;
		// the first pair after a rate change spans an uneven window, so four
		drain(4, pmc_pkg::DECIM_LO, 2'b11);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence; reset kept long enough for both domains
	initial begin
		rst = 1'b1;
		cfg = '0;
		cfg.rate = pmc_pkg::PMC_RATE_16K;
		aux_bit = 1'b0;
		ready = 1'b0;
		ovr_clr = 1'b0;
		num_errors = 0;
		checks_done = 0;
		t_last = 0;
		t_gap = 0;
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		s_clock();
		s_stereo();
		s_fill();
		s_aux();
		stop_test();
	end
endmodule

`default_nettype wire
